// [hdl/adc_ctl_regs.svh]
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// register byte offsets on the bus
`define ADC_OFF_TRIG_CTRL 12'h000
`define ADC_OFF_RES_HIGH 12'h004
`define ADC_OFF_RES_LOW 12'h008
`define ADC_OFF_CTRL 12'h00C
`define ADC_OFF_STATUS 12'h010
`define ADC_OFF_MASK 12'h014

// conversion_trigger_control fields
`define ADC_TRIG_SEL_LSB 4
`define ADC_TRIG_SEL_MSB 7
`define ADC_TRIG_CTRL_RST 8'h00
`define ADC_TRIG_NONE 4'h0

// control register field positions
`define ADC_CTRL_JUSTIFY_BIT 0
`define ADC_CTRL_IRQ_EN_BIT 1
`define ADC_CTRL_PERIPH_GATE_BIT 2
`define ADC_CTRL_GLOBAL_EN_BIT 3
`define ADC_CTRL_RC_CLK_BIT 4
`define ADC_CTRL_RST 5'h00

// status and mask field positions
`define ADC_ST_DONE_BIT 0
`define ADC_ST_T0_OVF_BIT 1
`define ADC_ST_T1_OVF_BIT 2
`define ADC_ST_RST 3'h0
`define ADC_MASK_RST 3'h0

// result registers
`define ADC_RES_RST 8'h00

`endif

// [hdl/adc_ctl_pkg.sv]
package adc_ctl_pkg;

    // bit k of the packed form belongs to trigger code k
    typedef struct packed {
        logic complementary_wave_unit_pin;
        logic auto_trigger_pin;
        logic pwm4_irq;
        logic pwm4_offset_match;
        logic pwm3_irq;
        logic pwm3_offset_match;
        logic pwm_two_offset_match;
        logic pwm_one_offset_match;
        logic comparator_two_sync_output;
        logic comparator_one_sync_output;
        logic timer_two_period_match;
        logic timer1_overflow;
        logic timer0_overflow;
        logic pwm2_irq;
        logic pwm1_irq;
        logic unused_code0;
    } trig_src_t;

    typedef struct packed {
        logic rc_clock_sel;
        logic global_irq_enable;
        logic peripheral_irq_gate;
        logic conversion_irq_enable;
        logic result_justify_select;
    } ctrl_t;

endpackage

// [hdl/rise_detect.sv]
`timescale 1ns/1ps
module rise_detect #(
    parameter int W = 16
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out
);
    logic [W-1:0] prev_ff;
    logic [W-1:0] nxt_prev;

    // reset to ones so a source already high at reset does not trigger
    always_comb begin
        nxt_prev = level_in;
        rise_out = level_in & ~prev_ff;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_ff <= '1;
        end else begin
            prev_ff <= nxt_prev;
        end
    end
endmodule

// [hdl/result_format.sv]
`timescale 1ns/1ps
module result_format #(
    parameter int RES_W = 10
) (
    input wire logic [RES_W-1:0] result_in,
    input wire logic justify_right_in,
    output logic [7:0] high_out,
    output logic [7:0] low_out
);
    logic [15:0] wide;

    always_comb begin
        if (justify_right_in) begin
            wide = {{(16-RES_W){1'b0}}, result_in};
        end else begin
            wide = {result_in, {(16-RES_W){1'b0}}};
        end
        high_out = wide[15:8];
        low_out = wide[7:0];
    end
endmodule

// [hdl/adc_trigger_result_irq.sv]
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "adc_ctl_regs.svh"
// Functional notes
// - The done flag is set at the end of every conversion whatever the interrupt enable says.
// - The conversion interrupt can be raised awake or asleep, and when asleep it wakes the part.
// - Conversions run in sleep only when the dedicated RC conversion clock is selected.
// - On wake, execution resumes in line if the global enable is clear, else it vectors.
// - The 10-bit result is placed left or right justified as the justify select bit says.
// - Right justified, the high register holds result bits 9:8 in bits 1:0.
// - Right justified, the low register holds result bits 7:0.
// - Codes 1 to 7 pick PWM1 irq, PWM2 irq, timer0, timer1, timer2 match, comparator 1 and 2.
// - Codes 8 to 13 pick PWM offset matches and irqs, 14 the trigger pin, 15 the wave unit pin.
// - Every selected trigger starts a conversion on its rising edge, never on its level.
// - A timer overflow used as trigger still sets that timer's own flag.
module adc_trigger_result_irq #(
    parameter int RES_W = 10,
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire adc_ctl_pkg::trig_src_t trig_src_in,
    input wire logic sleep_in,
    input wire logic conv_done_in,
    input wire logic [RES_W-1:0] conv_result_in,
    output logic conv_start_out,
    output logic conv_allowed_out,
    output logic conv_irq_req_out,
    output logic wake_out,
    output logic irq_vector_out,
    output logic resume_inline_out,
    output logic irq_out
);
    logic [3:0] trig_sel_ff;
    logic [3:0] nxt_trig_sel;
    adc_ctl_pkg::ctrl_t ctrl_ff;
    adc_ctl_pkg::ctrl_t nxt_ctrl;
    logic [2:0] status_ff;
    logic [2:0] nxt_status;
    logic [2:0] mask_ff;
    logic [2:0] nxt_mask;
    logic [7:0] res_hi_ff;
    logic [7:0] nxt_res_hi;
    logic [7:0] res_lo_ff;
    logic [7:0] nxt_res_lo;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic start_ff;
    logic nxt_start;
    logic allow_ff;
    logic nxt_allow;
    logic conv_req_ff;
    logic nxt_conv_req;
    logic wake_ff;
    logic nxt_wake;
    logic vector_ff;
    logic nxt_vector;
    logic resume_ff;
    logic nxt_resume;
    logic irq_ff;
    logic nxt_irq;

    logic [15:0] src_vec;
    logic [15:0] src_rise;
    logic [7:0] fmt_hi;
    logic [7:0] fmt_lo;
    logic setup;
    logic access;
    logic addr_hit;
    logic [2:0] set_events;
    logic [2:0] clr_bits;
    logic [7:0] trig_rd;

    assign src_vec = trig_src_in;

    rise_detect #(.W(16)) u_rise (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .level_in(src_vec),
        .rise_out(src_rise)
    );

    result_format #(.RES_W(RES_W)) u_fmt (
        .result_in(conv_result_in),
        .justify_right_in(ctrl_ff.result_justify_select),
        .high_out(fmt_hi),
        .low_out(fmt_lo)
    );

    // bus slave: one wait-free access cycle, read data captured in setup
    always_comb begin
        setup = psel_in & ~penable_in;
        access = psel_in & penable_in & pready_ff;
        addr_hit = (paddr_in == `ADC_OFF_TRIG_CTRL) || (paddr_in == `ADC_OFF_RES_HIGH)
            || (paddr_in == `ADC_OFF_RES_LOW) || (paddr_in == `ADC_OFF_CTRL)
            || (paddr_in == `ADC_OFF_STATUS) || (paddr_in == `ADC_OFF_MASK);
        trig_rd = {trig_sel_ff, 4'h0};
        nxt_pready = setup;
        nxt_pslverr = setup & ~addr_hit;
        nxt_prdata = 32'h0000_0000;
        if (setup && !pwrite_in) begin
            unique case (paddr_in)
                `ADC_OFF_TRIG_CTRL: nxt_prdata = {24'h00_0000, trig_rd};
                `ADC_OFF_RES_HIGH: nxt_prdata = {24'h00_0000, res_hi_ff};
                `ADC_OFF_RES_LOW: nxt_prdata = {24'h00_0000, res_lo_ff};
                `ADC_OFF_CTRL: nxt_prdata = {27'h000_0000, ctrl_ff};
                `ADC_OFF_STATUS: nxt_prdata = {29'h0000_0000, status_ff};
                `ADC_OFF_MASK: nxt_prdata = {29'h0000_0000, mask_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // register file
    always_comb begin
        nxt_trig_sel = trig_sel_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_res_hi = res_hi_ff;
        nxt_res_lo = res_lo_ff;
        clr_bits = 3'h0;
        if (access && pwrite_in) begin
            unique case (paddr_in)
                `ADC_OFF_TRIG_CTRL: nxt_trig_sel = pwdata_in[`ADC_TRIG_SEL_MSB:`ADC_TRIG_SEL_LSB];
                `ADC_OFF_RES_HIGH: nxt_res_hi = pwdata_in[7:0];
                `ADC_OFF_RES_LOW: nxt_res_lo = pwdata_in[7:0];
                `ADC_OFF_CTRL: nxt_ctrl = pwdata_in[4:0];
                `ADC_OFF_STATUS: clr_bits = pwdata_in[2:0];
                `ADC_OFF_MASK: nxt_mask = pwdata_in[2:0];
                default: clr_bits = 3'h0;
            endcase
        end
        // a finished conversion overrides a software write in the same cycle
        if (conv_done_in) begin
            nxt_res_hi = fmt_hi;
            nxt_res_lo = fmt_lo;
        end
    end

    // sticky flags: hardware set wins over a write-one clear
    always_comb begin
        set_events = 3'h0;
        set_events[`ADC_ST_DONE_BIT] = conv_done_in;
        set_events[`ADC_ST_T0_OVF_BIT] = src_rise[3];
        set_events[`ADC_ST_T1_OVF_BIT] = src_rise[4];
        nxt_status = (status_ff & ~clr_bits) | set_events;
        nxt_irq = |(nxt_status & nxt_mask);
    end

    // trigger selection, sleep gating, interrupt and wake
    always_comb begin
        nxt_allow = ~sleep_in | ctrl_ff.rc_clock_sel;
        nxt_start = (trig_sel_ff != `ADC_TRIG_NONE)
            && src_rise[trig_sel_ff]
            && nxt_allow;
        nxt_conv_req = nxt_status[`ADC_ST_DONE_BIT] & nxt_ctrl.conversion_irq_enable
            & nxt_ctrl.peripheral_irq_gate;
        nxt_wake = sleep_in & nxt_conv_req;
        nxt_vector = nxt_conv_req & nxt_ctrl.global_irq_enable;
        nxt_resume = nxt_wake & ~nxt_ctrl.global_irq_enable;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            trig_sel_ff <= `ADC_TRIG_NONE;
            ctrl_ff <= `ADC_CTRL_RST;
            status_ff <= `ADC_ST_RST;
            mask_ff <= `ADC_MASK_RST;
            res_hi_ff <= `ADC_RES_RST;
            res_lo_ff <= `ADC_RES_RST;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            start_ff <= 1'b0;
            allow_ff <= 1'b0;
            conv_req_ff <= 1'b0;
            wake_ff <= 1'b0;
            vector_ff <= 1'b0;
            resume_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            trig_sel_ff <= nxt_trig_sel;
            ctrl_ff <= nxt_ctrl;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            res_hi_ff <= nxt_res_hi;
            res_lo_ff <= nxt_res_lo;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            start_ff <= nxt_start;
            allow_ff <= nxt_allow;
            conv_req_ff <= nxt_conv_req;
            wake_ff <= nxt_wake;
            vector_ff <= nxt_vector;
            resume_ff <= nxt_resume;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign conv_start_out = start_ff;
    assign conv_allowed_out = allow_ff;
    assign conv_irq_req_out = conv_req_ff;
    assign wake_out = wake_ff;
    assign irq_vector_out = vector_ff;
    assign resume_inline_out = resume_ff;
    assign irq_out = irq_ff;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic wr_status_clr0;
    assign wr_status_clr0 = access && pwrite_in && (paddr_in == `ADC_OFF_STATUS) && pwdata_in[0];

    property p_done_sets_flag;
        conv_done_in |=> status_ff[`ADC_ST_DONE_BIT];
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag)
        else $error("done flag not set after conversion");

    property p_flag_sticky;
        status_ff[`ADC_ST_DONE_BIT] && !wr_status_clr0 |=> status_ff[`ADC_ST_DONE_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("done flag cleared without software");

    property p_wake_on_irq;
        sleep_in && status_ff[0] && ctrl_ff.conversion_irq_enable && ctrl_ff.peripheral_irq_gate
            && !wr_status_clr0 && !(access && pwrite_in) |=> wake_out && conv_irq_req_out;
    endproperty
    a_wake_on_irq: assert property (p_wake_on_irq)
        else $error("no wake on conversion interrupt in sleep");

    property p_sleep_no_start;
        sleep_in && !ctrl_ff.rc_clock_sel |=> !conv_start_out && !conv_allowed_out;
    endproperty
    a_sleep_no_start: assert property (p_sleep_no_start)
        else $error("conversion started in sleep without RC clock");

    property p_resume_inline;
        wake_out && !ctrl_ff.global_irq_enable |-> resume_inline_out && !irq_vector_out;
    endproperty
    a_resume_inline: assert property (p_resume_inline)
        else $error("wake did not resume in line");

    property p_right_justify;
        conv_done_in && ctrl_ff.result_justify_select |=>
            res_hi_ff == {6'h00, $past(conv_result_in[9:8])}
            && res_lo_ff == $past(conv_result_in[7:0]);
    endproperty
    a_right_justify: assert property (p_right_justify)
        else $error("right justified result misplaced");

    property p_left_justify;
        conv_done_in && !ctrl_ff.result_justify_select |=>
            res_hi_ff == $past(conv_result_in[9:2])
            && res_lo_ff == {$past(conv_result_in[1:0]), 6'h00};
    endproperty
    a_left_justify: assert property (p_left_justify)
        else $error("left justified result misplaced");

    sequence s_sel_low;
        trig_sel_ff != `ADC_TRIG_NONE && !src_vec[trig_sel_ff];
    endsequence
    sequence s_sel_high;
        $stable(trig_sel_ff) && src_vec[trig_sel_ff] && (!sleep_in || ctrl_ff.rc_clock_sel);
    endsequence
    property p_edge_starts;
        s_sel_low ##1 s_sel_high |=> conv_start_out;
    endproperty
    a_edge_starts: assert property (p_edge_starts)
        else $error("rising trigger edge did not start a conversion");

    property p_level_no_start;
        src_vec[trig_sel_ff] && $past(src_vec[trig_sel_ff]) && $stable(trig_sel_ff)
            |=> !conv_start_out;
    endproperty
    a_level_no_start: assert property (p_level_no_start)
        else $error("held trigger level restarted a conversion");

    property p_trig_off;
        trig_sel_ff == `ADC_TRIG_NONE |=> !conv_start_out;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("conversion started with triggering off");

    property p_timer_flag;
        trig_src_in.timer0_overflow && !$past(trig_src_in.timer0_overflow) && $past(arst_n_in)
            |=> status_ff[1];
    endproperty
    a_timer_flag: assert property (p_timer_flag)
        else $error("timer0 overflow did not set its flag");

    property p_irq_req;
        status_ff[0] && ctrl_ff.conversion_irq_enable && ctrl_ff.peripheral_irq_gate
            && !(access && pwrite_in) |=> conv_irq_req_out;
    endproperty
    a_irq_req: assert property (p_irq_req)
        else $error("conversion interrupt request missing");
endmodule

// [dv/conv_core_model.sv]
`timescale 1ns/1ps
module conv_core_model (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic [3:0] delay_in,
    input wire logic [9:0] value_in,
    output logic done_out,
    output logic [9:0] result_out
);
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_done = (cnt_ff == 5'h01);
        if (start_in) begin
            nxt_cnt = {1'b0, delay_in} + 5'h01;
        end else if (cnt_ff != 5'h00) begin
            nxt_cnt = cnt_ff - 5'h01;
        end
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= 5'h00;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end
    assign done_out = done_ff;
    // result is inverted outside the done pulse so stale data cannot pass
    assign result_out = done_ff ? value_in : ~value_in;
endmodule

// [dv/adc_trigger_result_irq_test.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module adc_trigger_result_irq_test;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
    typedef struct packed {logic j; logic [9:0] v; logic [7:0] h; logic [7:0] l;} jrow_t;
    row_t rows [6] = '{'{12'h000, 32'h000000FF, 32'h000000F0, 1'b0},
        '{12'h00C, 32'h0000001F, 32'h0000001F, 1'b0}, '{12'h014, 32'h00000007, 32'h00000007, 1'b0},
        '{12'h004, 32'h000000A5, 32'h000000A5, 1'b0}, '{12'h008, 32'h0000005A, 32'h0000005A, 1'b0},
        '{12'h018, 32'h000000FF, 32'h00000000, 1'b1}};
    jrow_t jrows [4] = '{'{1'b0, 10'h2B7, 8'hAD, 8'hC0}, '{1'b1, 10'h2B7, 8'h02, 8'hB7},
        '{1'b0, 10'h148, 8'h52, 8'h00}, '{1'b1, 10'h148, 8'h01, 8'h48}};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] trig = 16'h0000;
    logic sleep = 1'b0;
    logic [9:0] value = 10'h000;
    logic [3:0] delay = 4'h1;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [9:0] result;
    logic pready, pslverr, err, done, start, allowed, req, wake, vec, resume, irq;
    int bad_count = 0;
    int check_count = 0;
    int start_count = 0;
    int done_count = 0;

    adc_trigger_result_irq dut (.core_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .trig_src_in(adc_ctl_pkg::trig_src_t'(trig)), .sleep_in(sleep), .conv_done_in(done),
        .conv_result_in(result), .conv_start_out(start), .conv_allowed_out(allowed),
        .conv_irq_req_out(req), .wake_out(wake), .irq_vector_out(vec),
        .resume_inline_out(resume), .irq_out(irq));
    conv_core_model core (.core_clk_in(clk), .arst_n_in(arst_n), .start_in(start),
        .delay_in(delay), .value_in(value), .done_out(done), .result_out(result));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (start !== 1'b0) start_count <= start_count + 1;
        if (done !== 1'b0) done_count <= done_count + 1;
    end

    task automatic final_report();
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            final_report();
        end
    endtask

    // drive a source pattern from all-low and count starts and finished conversions
    task automatic conv(input logic [15:0] pat, input int exp);
        int s0, d0, n;
        trig <= 16'h0000;
        repeat (3) @(posedge clk);
        s0 = start_count;
        d0 = done_count;
        trig <= pat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done_count == d0 && n < 40);
        repeat (3) @(posedge clk);
        `CHK(start_count - s0, exp)
        `CHK(done_count - d0, exp)
        delay <= delay ^ 4'hF;
    endtask

    task automatic wr_ctrl(input logic [31:0] d);
        apb(1'b1, 12'h00C, d);
        repeat (3) @(posedge clk);
    endtask

    initial begin
        #500000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h00000000);
            `CHK(rd, rows[i].r)
            `CHK(err, rows[i].e)
        end
        wr_ctrl(32'h00000000);
        apb(1'b1, 12'h014, 32'h00000000);
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, 12'h000, 32'(k * 16));
            conv(16'hFFFF ^ (16'h0001 << k), 0);
            if (k > 0) conv(16'h0001 << k, 1);
        end
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd, 32'h00000007)
        repeat (5) @(posedge clk);
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd, 32'h00000007)
        apb(1'b1, 12'h010, 32'h00000007);
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd, 32'h00000000)
        foreach (jrows[i]) begin
            wr_ctrl(32'(jrows[i].j));
            value <= jrows[i].v;
            conv(16'h8000, 1);
            apb(1'b0, 12'h004, 32'h00000000);
            `CHK(rd, 32'(jrows[i].h))
            apb(1'b0, 12'h008, 32'h00000000);
            `CHK(rd, 32'(jrows[i].l))
        end
        apb(1'b1, 12'h010, 32'h00000001);
        wr_ctrl(32'h00000002);
        conv(16'h8000, 1);
        `CHK(req, 1'b0)
        wr_ctrl(32'h00000006);
        `CHK(req, 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h014, 32'h00000001);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        apb(1'b1, 12'h010, 32'h00000001);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(req, 1'b0)
        sleep <= 1'b1;
        wr_ctrl(32'h00000006);
        `CHK(allowed, 1'b0)
        conv(16'h8000, 0);
        wr_ctrl(32'h00000016);
        `CHK(allowed, 1'b1)
        conv(16'h8000, 1);
        `CHK(wake, 1'b1)
        `CHK(resume, 1'b1)
        `CHK(vec, 1'b0)
        wr_ctrl(32'h0000001E);
        `CHK(vec, 1'b1)
        `CHK(resume, 1'b0)
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(wake, 1'b0)
        arst_n <= 1'b1;
        sleep <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 12'(a * 4), 32'h00000000);
            `CHK(rd, 32'h00000000)
        end
        final_report();
    end
endmodule
